/* File: core_int_map.vh */
`ifndef CORE_INT_MAP_VH
`define CORE_INT_MAP_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define MAP_MAIN_CTRL 4'h0
`define MAP_EDGE_CTRL 4'h4
`define MAP_EXT_CTRL 4'h8
`define MAP_PRIO_MODE 4'hc
// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_MAIN_CTRL 8'h00
`define RST_EDGE_CTRL 8'hf5
`define RST_EXT_CTRL 8'hc0
// ----------------------------------------
// readable bit masks
// ----------------------------------------
`define MASK_EDGE_CTRL 8'hf5
`define MASK_EXT_CTRL 8'hdb
// ----------------------------------------
// main control fields
// ----------------------------------------
`define B_GLOBAL_HI 7
`define B_PERIPH_LO 6
`define B_TIMER_ZERO_EN 5
`define B_EXT0_EN 4
`define B_PORT_EN 3
`define B_TIMER_ZERO_FLAG 2
`define B_EXT0_FLAG 1
`define B_PORT_FLAG 0
// ----------------------------------------
// edge/pull-up/priority fields
// ----------------------------------------
`define B_PULLUP_OFF 7
`define B_EDGE0 6
`define B_EDGE1 5
`define B_EDGE2 4
`define B_TIMER_ZERO_PRIO 2
`define B_PORT_PRIO 0
// ----------------------------------------
// external pin fields
// ----------------------------------------
`define B_EXT2_PRIO 7
`define B_EXT1_PRIO 6
`define B_EXT2_EN 4
`define B_EXT1_EN 3
`define B_EXT2_FLAG 1
`define B_EXT1_FLAG 0
// ----------------------------------------
// vectors and responses
// ----------------------------------------
`define VEC_HIGH 24'h000008
`define VEC_LOW 24'h000018
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: core_interrupt_control_regs.v */
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "core_int_map.vh"
module core_interrupt_control_regs (
	input wire clk,
	input wire rst,
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire timerZeroOverflow,
	input wire extPinZero,
	input wire extPinOne,
	input wire extPinTwo,
	input wire [3:0] upperPortNibble,
	input wire changeDetectPortRead,
	input wire [7:0] portLatch,
	input wire intAck,
	input wire returnFromInterruptInstr,
	output reg intRequest,
	output reg [23:0] intVector,
	output reg highActive,
	output reg lowActive,
	output reg [7:0] pullupEnable
);
	// ----------------------------------------
	// register state
	// ----------------------------------------
	reg [7:0] mainCtrl;
	reg [7:0] edgeCtrl;
	reg [7:0] extCtrl;
	reg priorityModeEnable;
	reg [3:0] portSeen;
	reg [2:0] pinSync1;
	reg [2:0] pinSync2;
	reg [2:0] pinPrev;
	reg [3:0] portSync1;
	reg [3:0] portSync2;
	reg [3:0] pendAddr;
	reg [31:0] pendData;
	reg [3:0] pendStrb;
	reg haveAddr;
	reg haveData;
	// ----------------------------------------
	// pin synchronisers and edge detect
	// ----------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pinSync1 <= 3'h0;
			pinSync2 <= 3'h0;
			pinPrev <= 3'h0;
		end else begin
			pinSync1 <= {extPinTwo, extPinOne, extPinZero};
			pinSync2 <= pinSync1;
			pinPrev <= pinSync2;
		end
	end
	// ----------------------------------------
	// port synchroniser
	// ----------------------------------------
	// two flops: the port pins are asynchronous
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			portSync1 <= 4'h0;
			portSync2 <= 4'h0;
		end else begin
			portSync1 <= upperPortNibble;
			portSync2 <= portSync1;
		end
	end
	// ----------------------------------------
	// edge select
	// ----------------------------------------
	// pins idle low: one held high through reset reads as a rising edge
	wire [2:0] edgeSel = {edgeCtrl[`B_EDGE2], edgeCtrl[`B_EDGE1], edgeCtrl[`B_EDGE0]};
	wire [2:0] pinEdge;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_edge
			// rising when 1, falling when 0
			assign pinEdge[gi] = edgeSel[gi] ? (pinSync2[gi] & ~pinPrev[gi])
				: (~pinSync2[gi] & pinPrev[gi]);
		end
	endgenerate
	// ----------------------------------------
	// port change detect
	// ----------------------------------------
	// last-read value resets to zero: a nonzero port after reset raises the flag
	// mismatch against last-read value
	wire portMismatch = (portSync2 != portSeen);
	// ----------------------------------------
	// bus write handshake
	// ----------------------------------------
	wire awTake = s_axi_awvalid & s_axi_awready;
	wire wTake = s_axi_wvalid & s_axi_wready;
	wire [3:0] wrAddr = awTake ? s_axi_awaddr : pendAddr;
	wire [31:0] wrData = wTake ? s_axi_wdata : pendData;
	wire [3:0] wrStrb = wTake ? s_axi_wstrb : pendStrb;
	wire doWrite = (haveAddr | awTake) & (haveData | wTake) & ~s_axi_bvalid;
	// ----------------------------------------
	// write decode
	// ----------------------------------------
	// only byte lane 0 carries a register
	wire wrLane = doWrite & wrStrb[0];
	wire wrMain = wrLane & (wrAddr == `MAP_MAIN_CTRL);
	wire wrEdge = wrLane & (wrAddr == `MAP_EDGE_CTRL);
	wire wrExt = wrLane & (wrAddr == `MAP_EXT_CTRL);
	wire wrMode = wrLane & (wrAddr == `MAP_PRIO_MODE);
	wire wrMapped = (wrAddr == `MAP_MAIN_CTRL) | (wrAddr == `MAP_EDGE_CTRL)
		| (wrAddr == `MAP_EXT_CTRL) | (wrAddr == `MAP_PRIO_MODE);
	// ----------------------------------------
	// write channel state
	// ----------------------------------------
	// one write at a time: readies stay low until the response is taken
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			haveAddr <= 1'b0;
			haveData <= 1'b0;
			pendAddr <= 4'h0;
			pendData <= 32'h0;
			pendStrb <= 4'h0;
		end else begin
			s_axi_awready <= ~haveAddr & ~awTake & ~s_axi_bvalid & ~doWrite;
			s_axi_wready <= ~haveData & ~wTake & ~s_axi_bvalid & ~doWrite;
			if (awTake) begin
				pendAddr <= s_axi_awaddr;
			end
			if (wTake) begin
				pendData <= s_axi_wdata;
				pendStrb <= s_axi_wstrb;
			end
			if (doWrite) begin
				haveAddr <= 1'b0;
				haveData <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
			end else begin
				if (awTake) begin
					haveAddr <= 1'b1;
				end
				if (wTake) begin
					haveData <= 1'b1;
				end
				if (s_axi_bvalid & s_axi_bready) begin
					s_axi_bvalid <= 1'b0;
				end
			end
		end
	end
	// ----------------------------------------
	// interrupt decision
	// ----------------------------------------
	// ----------------------------------------
	// per-source flag, enable and priority
	// ----------------------------------------
	// timer overflow flag
	wire timerFlag = mainCtrl[`B_TIMER_ZERO_FLAG];
	wire pin0Flag = mainCtrl[`B_EXT0_FLAG];
	wire portFlag = mainCtrl[`B_PORT_FLAG];
	wire pin1Flag = extCtrl[`B_EXT1_FLAG];
	wire pin2Flag = extCtrl[`B_EXT2_FLAG];
	wire timerEn = mainCtrl[`B_TIMER_ZERO_EN];
	wire pin0En = mainCtrl[`B_EXT0_EN];
	wire portEn = mainCtrl[`B_PORT_EN];
	wire pin1En = extCtrl[`B_EXT1_EN];
	wire pin2En = extCtrl[`B_EXT2_EN];
	wire timerPrio = edgeCtrl[`B_TIMER_ZERO_PRIO];
	// pin 0 has no priority bit: always high
	wire pin0Prio = 1'b1;
	wire portPrio = edgeCtrl[`B_PORT_PRIO];
	wire pin1Prio = extCtrl[`B_EXT1_PRIO];
	wire pin2Prio = extCtrl[`B_EXT2_PRIO];
	// source order: pin 2, pin 1, port, pin 0, timer
	wire [4:0] srcFlag = {pin2Flag, pin1Flag, portFlag, pin0Flag, timerFlag};
	wire [4:0] srcEn = {pin2En, pin1En, portEn, pin0En, timerEn};
	wire [4:0] srcPrio = {pin2Prio, pin1Prio, portPrio, pin0Prio, timerPrio};
	// ----------------------------------------
	// level requests
	// ----------------------------------------
	wire [4:0] srcLive = srcFlag & srcEn;
	// per-source priority only in priority mode
	wire [4:0] isHigh = priorityModeEnable ? srcPrio : 5'h1f;
	// flag, enable and level gates all set
	wire hiReq = priorityModeEnable & mainCtrl[`B_GLOBAL_HI] & (|(srcLive & isHigh));
	// low waits while high routine runs
	wire loReq = priorityModeEnable & mainCtrl[`B_PERIPH_LO] & ~highActive
		& (|(srcLive & ~isHigh));
	// bit 7 master gate in compatible mode
	// all sources here are core ones, bit 6 not needed
	wire compReq = ~priorityModeEnable & mainCtrl[`B_GLOBAL_HI] & (|srcLive);
	wire anyHigh = (hiReq | compReq) & ~highActive;
	wire anyLow = loReq & ~lowActive;
	wire takeHigh = intAck & anyHigh;
	wire takeLow = intAck & ~anyHigh & anyLow;
	// ----------------------------------------
	// control registers
	// ----------------------------------------
	wire [2:0] pinFlagSet = pinEdge;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			mainCtrl <= `RST_MAIN_CTRL;
			edgeCtrl <= `RST_EDGE_CTRL;
			extCtrl <= `RST_EXT_CTRL;
			priorityModeEnable <= 1'b0;
			portSeen <= 4'h0;
			highActive <= 1'b0;
			lowActive <= 1'b0;
		end else begin
			if (wrMain) begin
				mainCtrl <= wrData[7:0];
			end
			if (wrEdge) begin
				edgeCtrl <= wrData[7:0] & `MASK_EDGE_CTRL;
			end
			if (wrExt) begin
				extCtrl <= wrData[7:0] & `MASK_EXT_CTRL;
			end
			if (wrMode) begin
				priorityModeEnable <= wrData[7];
			end
			if (changeDetectPortRead) begin
				portSeen <= portSync2;
			end
			// sets ignore enables; set beats clear
			if (timerZeroOverflow) begin
				mainCtrl[`B_TIMER_ZERO_FLAG] <= 1'b1;
			end
			if (pinFlagSet[0]) begin
				mainCtrl[`B_EXT0_FLAG] <= 1'b1;
			end
			if (portMismatch) begin
				mainCtrl[`B_PORT_FLAG] <= 1'b1;
			end
			if (pinFlagSet[1]) begin
				extCtrl[`B_EXT1_FLAG] <= 1'b1;
			end
			if (pinFlagSet[2]) begin
				extCtrl[`B_EXT2_FLAG] <= 1'b1;
			end
			// take and return beat a software write of bits 7 and 6
			// clear gating enable when taken
			if (takeHigh) begin
				mainCtrl[`B_GLOBAL_HI] <= 1'b0;
				highActive <= 1'b1;
			end else if (takeLow) begin
				mainCtrl[`B_PERIPH_LO] <= 1'b0;
				lowActive <= 1'b1;
			end else if (returnFromInterruptInstr) begin
				// return sets enable of routine left
				if (highActive) begin
					mainCtrl[`B_GLOBAL_HI] <= 1'b1;
					highActive <= 1'b0;
				end else if (lowActive) begin
					mainCtrl[`B_PERIPH_LO] <= 1'b1;
					lowActive <= 1'b0;
				end
			end
		end
	end
	// ----------------------------------------
	// core-facing outputs
	// ----------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			intRequest <= 1'b0;
			intVector <= `VEC_HIGH;
			pullupEnable <= 8'h00;
		end else begin
			// drop in the take cycle so one request gets one ack
			intRequest <= (anyHigh | anyLow) & ~takeHigh & ~takeLow;
			intVector <= anyHigh ? `VEC_HIGH : (anyLow ? `VEC_LOW : `VEC_HIGH);
			// pull-ups off globally or by latch
			pullupEnable <= edgeCtrl[`B_PULLUP_OFF] ? 8'h00 : portLatch;
		end
	end
	// ----------------------------------------
	// bus read
	// ----------------------------------------
	// live address decode: arready only rises while rvalid is low
	reg [7:0] rdByte;
	reg rdHit;
	always @* begin
		rdByte = 8'h00;
		rdHit = 1'b1;
		case (s_axi_araddr)
			`MAP_MAIN_CTRL: rdByte = mainCtrl;
			`MAP_EDGE_CTRL: rdByte = edgeCtrl & `MASK_EDGE_CTRL;
			`MAP_EXT_CTRL: rdByte = extCtrl & `MASK_EXT_CTRL;
			`MAP_PRIO_MODE: rdByte = {priorityModeEnable, 7'h00};
			default: rdHit = 1'b0;
		endcase
	end
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h0, rdByte};
				s_axi_rresp <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

/* File: core_int_assertions.sv */
`timescale 1ns/1ps
`include "core_int_map.vh"
module core_int_assertions (
	input wire clk,
	input wire rst,
	input wire s_axi_awready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire intAck,
	input wire intRequest,
	input wire [23:0] intVector,
	input wire highActive,
	input wire lowActive,
	input wire [7:0] pullupEnable,
	input wire [7:0] portLatch
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ------
	// bus
	// ------
	chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("address taken during response");
	// ------
	// interrupts
	// ------
	sequence takeHigh;
		intAck && intRequest && intVector == `VEC_HIGH;
	endsequence
	sequence takeLow;
		intAck && intRequest && intVector == `VEC_LOW;
	endsequence
	chk_vector_legal: assert property (intRequest |->
		intVector == `VEC_HIGH || intVector == `VEC_LOW) else $error("bad vector");
	chk_high_gate: assert property (takeHigh |-> ##[1:2] !intRequest)
		else $error("request stays after take");
	chk_low_active: assert property (takeLow |=> lowActive)
		else $error("low routine not marked");
	chk_low_blocked: assert property (highActive [*2] |->
		!(intRequest && intVector == `VEC_LOW)) else $error("low request in high routine");
	chk_pullup_follow: assert property (
		(pullupEnable & ~$past(portLatch)) == 8'h0) else $error("pull-up without latch");
endmodule

/* File: core_side_model.sv */
`timescale 1ns/1ps
module core_side_model (
	input wire clk,
	input wire rst,
	input wire run,
	input wire slow,
	input wire intRequest,
	input wire [23:0] intVector,
	output logic intAck,
	output logic returnFromInterruptInstr,
	output logic [23:0] taken,
	output int takes
);
	int lag;
	int busy;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			intAck <= 1'h0;
			returnFromInterruptInstr <= 1'h0;
			taken <= 24'h0;
			takes <= 0;
			lag <= 0;
			busy <= 0;
		end else begin
			intAck <= 1'h0;
			returnFromInterruptInstr <= 1'h0;
			if (busy > 0) begin
				busy <= busy - 1;
				returnFromInterruptInstr <= busy == 1;
			end else if (run && intRequest && !intAck) begin
				if (lag < (slow ? 3 : 0)) begin
					lag <= lag + 1;
				end else begin
					intAck <= 1'h1;
					taken <= intVector;
					takes <= takes + 1;
					lag <= 0;
					busy <= 30;
				end
			end
		end
	end
endmodule

/* File: core_interrupt_control_regs_tb.sv */
`timescale 1ns/1ps
`include "core_int_map.vh"
module core_interrupt_control_regs_tb;
	logic clk = 0, rst = 1, run = 0, slow = 0;
	logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, intAck, returnFromInterruptInstr, intRequest, highActive, lowActive;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [1:0] expResp = `RESP_OKAY;
	logic timerZeroOverflow = 0, extPinZero = 0, extPinOne = 0, extPinTwo = 0;
	logic changeDetectPortRead = 0;
	logic [3:0] upperPortNibble = 0;
	logic [7:0] portLatch = 8'ha5, pullupEnable;
	logic [23:0] intVector, taken;
	int numErrors = 0, nChecks = 0, cyc = 0, takes;
	core_interrupt_control_regs dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.timerZeroOverflow, .extPinZero, .extPinOne, .extPinTwo, .upperPortNibble,
		.changeDetectPortRead, .portLatch, .intAck, .returnFromInterruptInstr,
		.intRequest, .intVector, .highActive, .lowActive, .pullupEnable);
	core_side_model core (.clk, .rst, .run, .slow, .intRequest, .intVector, .intAck,
		.returnFromInterruptInstr, .taken, .takes);
	initial begin
		forever #2 clk = ~clk;
	end
	// ------
	// tasks
	// ------
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		nChecks++;
		if (s !== e) begin
			numErrors++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 0;
		chk("bresp", s_axi_bresp, expResp);
	endtask
	task rchk(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 0;
		chk("register", s_axi_rdata, {24'h0, e});
		chk("rresp", s_axi_rresp, expResp);
	endtask
	task pulseTimer;
		@(posedge clk) timerZeroOverflow <= 1;
		@(posedge clk) timerZeroOverflow <= 0;
	endtask
	task pins(input logic v);
		@(posedge clk) {extPinZero, extPinOne, extPinTwo} <= {3{v}};
		repeat (6) @(posedge clk);
	endtask
	task finalReport;
		$display("checks %0d mismatches %0d", nChecks, numErrors);
		if (numErrors == 0 && nChecks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			numErrors++;
			finalReport;
		end
	end
	// ------
	// tests
	// ------
	initial begin
		repeat (8) @(posedge clk);
		rst <= 0;
		rchk(4'h0, 8'h00);
		rchk(4'h4, 8'hf5);
		rchk(4'h8, 8'hc0);
		rchk(4'hc, 8'h00);
		expResp = `RESP_SLVERR;
		rchk(4'h2, 8'h00);
		wr(4'h2, 8'hff);
		expResp = `RESP_OKAY;
		chk("pullups", pullupEnable, 8'h00);
		wr(4'h4, 8'hff);
		rchk(4'h4, 8'hf5);
		wr(4'h8, 8'hfc);
		rchk(4'h8, 8'hd8);
		wr(4'h4, 8'h75);
		repeat (3) @(posedge clk);
		chk("pullups", pullupEnable, 8'ha5);
		$display("test registers done");
		pulseTimer;
		rchk(4'h0, 8'h04);
		wr(4'h0, 8'h00);
		rchk(4'h0, 8'h00);
		pins(1);
		rchk(4'h0, 8'h02);
		rchk(4'h8, 8'hdb);
		wr(4'h0, 8'h00);
		wr(4'h8, 8'hd8);
		pins(0);
		rchk(4'h8, 8'hd8);
		wr(4'h4, 8'h05);
		pins(1);
		pins(0);
		rchk(4'h0, 8'h02);
		rchk(4'h8, 8'hdb);
		wr(4'h0, 8'h00);
		wr(4'h8, 8'hc0);
		@(posedge clk) upperPortNibble <= 4'h3;
		repeat (4) @(posedge clk);
		wr(4'h0, 8'h00);
		rchk(4'h0, 8'h01);
		@(posedge clk) changeDetectPortRead <= 1;
		@(posedge clk) changeDetectPortRead <= 0;
		wr(4'h0, 8'h00);
		rchk(4'h0, 8'h00);
		$display("test events done");
		wr(4'h0, 8'ha0);
		run <= 1;
		pulseTimer;
		repeat (20) if (takes < 1) @(posedge clk);
		run <= 0;
		chk("vector", taken, `VEC_HIGH);
		rchk(4'h0, 8'h24);
		chk("high active", highActive, 1'h1);
		repeat (40) @(posedge clk);
		rchk(4'h0, 8'ha4);
		chk("high active", highActive, 1'h0);
		chk("request", intRequest, 1'h1);
		wr(4'h0, 8'h00);
		repeat (3) @(posedge clk);
		chk("request", intRequest, 1'h0);
		$display("test compatible done");
		wr(4'hc, 8'h80);
		wr(4'h4, 8'h71);
		wr(4'h0, 8'ha0);
		run <= 1;
		slow <= 1;
		pulseTimer;
		repeat (4) @(posedge clk);
		chk("request", intRequest, 1'h0);
		wr(4'h0, 8'h64);
		repeat (20) if (takes < 2) @(posedge clk);
		run <= 0;
		chk("vector", taken, `VEC_LOW);
		rchk(4'h0, 8'h24);
		chk("low active", lowActive, 1'h1);
		repeat (40) @(posedge clk);
		wr(4'h0, 8'h00);
		$display("test priority done");
		finalReport;
	end
endmodule
bind core_interrupt_control_regs core_int_assertions chk (.clk, .rst, .s_axi_awready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .intAck, .intRequest, .intVector, .highActive, .lowActive,
	.pullupEnable, .portLatch);
